// file: src/cfh_consts.vh
`ifndef CFH_CONSTS_VH
`define CFH_CONSTS_VH

// Filter build, fixed at one documented choice
`define CFH_IN_WIDTH        16
`define CFH_IN_PAD_WIDTH    16
`define CFH_OUT_WIDTH       20
`define CFH_OUT_PAD_WIDTH   24
`define CFH_NUM_CHAN        4
`define CFH_CHAN_WIDTH      2
`define CFH_USER_WIDTH      16
`define CFH_SYNC_BIT        8
`define CFH_RATE_WIDTH      14
`define CFH_RATE_PAD_WIDTH  16
`define CFH_MAX_RATE        14'h2000
`define CFH_MIN_RATE        14'h0004
`define CFH_RESET_RATE      14'h0004

// Reset timing
`define CFH_RESET_MIN_NS    40
`define CFH_CLK_NS          20
`define CFH_RESET_CYCLES    ((`CFH_RESET_MIN_NS + `CFH_CLK_NS - 1) / `CFH_CLK_NS)
`define CFH_RESET_CNT_W     4

// Software register addresses
`define CFH_ADDR_W          4
`define CFH_REG_CTRL        4'h0
`define CFH_REG_RATE        4'h1
`define CFH_REG_SAMPLE      4'h2
`define CFH_REG_STATUS      4'h3
`define CFH_REG_OUT_DATA    4'h4
`define CFH_REG_OUT_USER    4'h5
`define CFH_REG_COUNT       4'h6

// Control bit positions
`define CFH_CTRL_RESET      0
`define CFH_CTRL_BP_EN      1
`define CFH_CTRL_OUT_STALL  2

// Status bit positions
`define CFH_ST_CFG_BUSY     0
`define CFH_ST_IN_BUSY      1
`define CFH_ST_OUT_AVAIL    2
`define CFH_ST_RESET_BUSY   3
`define CFH_ST_OUT_LAST     4
`define CFH_ST_OVERRUN      5

`endif

// file: src/cfh_stream_src.v
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// One-word stream source: holds a payload until the handshake takes it
module cfh_stream_src #(
    parameter W = 16
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         rst_n_i,
    // Load side
    input  wire         load_i,
    input  wire [W-1:0] load_data_i,
    input  wire         load_last_i,
    output wire         busy_o,
    // Stream side
    output reg          tvalid_o,
    output reg  [W-1:0] tdata_o,
    output reg          tlast_o,
    input  wire         tready_i
);

    // Busy while a word waits; a new load is refused then
    assign busy_o = tvalid_o;

    // Valid held until accepted, payload stable meanwhile
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            tvalid_o <= 1'b0;
            tdata_o  <= {W{1'b0}};
            tlast_o  <= 1'b0;
        end else if (tvalid_o && tready_i) begin
            tvalid_o <= 1'b0;
        end else if (load_i && !tvalid_o) begin
            tvalid_o <= 1'b1;
            tdata_o  <= load_data_i;
            tlast_o  <= load_last_i;
        end
    end

endmodule // cfh_stream_src

`default_nettype wire

// file: src/cfh_host.v
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cfh_consts.vh"

// What this block does
// - Reset held low at least two cycles
// - Channels carry valid and data, extras optional
// - Transfer only when valid and ready high
// - Sender drives valid, receiver drives ready
// - Sub-fields packed little-endian from bit zero
// - Vectors padded to multiples of eight bits
// - Rate padded to byte, padding constant
// - Configurator offers valid, filter answers ready
// - Samples twos-complement, 2 to 32 bits
// - Input sample padded to byte boundary
// - Source raises valid when sample present
// - Valid may be tied high without strobe

module cfh_host (
    // Clock and reset
    input  wire                              CLK_SYS_I,
    input  wire                              RST_N_I,
    // Software register port
    input  wire [`CFH_ADDR_W-1:0]            REG_ADDR_I,
    input  wire [31:0]                       REG_WDATA_I,
    input  wire                              REG_WR_I,
    input  wire                              REG_RD_I,
    output reg  [31:0]                       REG_RDATA_O,
    // Filter reset
    output reg                               FLT_RESET_N_O,
    // Configuration channel towards the filter
    output wire                              CFG_TVALID_O,
    output wire [`CFH_RATE_PAD_WIDTH-1:0]    CFG_TDATA_O,
    input  wire                              CFG_TREADY_I,
    // Data input channel towards the filter
    output wire                              DIN_TVALID_O,
    output wire [`CFH_IN_PAD_WIDTH-1:0]      DIN_TDATA_O,
    output wire                              DIN_TLAST_O,
    input  wire                              DIN_TREADY_I,
    // Data output channel from the filter
    input  wire                              DOUT_TVALID_I,
    input  wire [`CFH_OUT_PAD_WIDTH-1:0]     DOUT_TDATA_I,
    input  wire [`CFH_USER_WIDTH-1:0]        DOUT_TUSER_I,
    input  wire                              DOUT_TLAST_I,
    output wire                              DOUT_TREADY_O,
    // Filter events, observed only
    input  wire                              EVT_LAST_MISSING_I,
    input  wire                              EVT_LAST_UNEXPECTED_I
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer states, one-hot
    localparam [2:0] RS_IDLE = 3'b001;
    localparam [2:0] RS_HOLD = 3'b010;
    localparam [2:0] RS_DONE = 3'b100;

    // Pack a rate value: field at bit 0, constant zero padding
    function [`CFH_RATE_PAD_WIDTH-1:0] pack_rate;
        input [31:0] v;
        begin
            pack_rate = {{(`CFH_RATE_PAD_WIDTH-`CFH_RATE_WIDTH){1'b0}},
                         v[`CFH_RATE_WIDTH-1:0]};
        end
    endfunction

    // Pack a sample: twos-complement field at bit 0, field fills the padded width
    function [`CFH_IN_PAD_WIDTH-1:0] pack_sample;
        input [31:0] v;
        begin
            pack_sample = v[`CFH_IN_PAD_WIDTH-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [2:0]                   rs_state_q;        // Reset sequencer state
    reg  [2:0]                   rs_state_d;
    reg  [`CFH_RESET_CNT_W-1:0]  rs_cnt_q;          // Reset low cycle count
    reg  [`CFH_RESET_CNT_W-1:0]  rs_cnt_d;
    reg                          bp_en_q;           // Backpressure enable, software control bit
    reg                          out_stall_q;       // Software stall of output
    reg  [`CFH_RATE_WIDTH-1:0]   rate_q;            // Last rate offered
    reg  [`CFH_OUT_PAD_WIDTH-1:0] out_data_q;       // Captured output sample
    reg  [`CFH_USER_WIDTH-1:0]   out_user_q;        // Captured side-band
    reg                          out_last_q;        // Captured end marker
    reg                          out_avail_q;       // Unread output sample
    reg                          overrun_q;         // Sample lost unread
    reg  [15:0]                  out_cnt_q;         // Output samples taken
    reg  [`CFH_CHAN_WIDTH-1:0]   in_chan_q;         // Next input channel

    // Decoded writes and the output data read
    wire wr_ctrl   = REG_WR_I && (REG_ADDR_I == `CFH_REG_CTRL);
    wire wr_rate   = REG_WR_I && (REG_ADDR_I == `CFH_REG_RATE);
    wire wr_sample = REG_WR_I && (REG_ADDR_I == `CFH_REG_SAMPLE);
    wire rd_data   = REG_RD_I && (REG_ADDR_I == `CFH_REG_OUT_DATA);

    // Channel busy flags from the sources, and the filter reset flag from the sequencer
    wire cfg_busy;
    wire din_busy;
    wire flt_in_reset = (rs_state_q != RS_DONE);

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer next state: filter reset held a minimum count
    always @* begin
        rs_state_d = rs_state_q;
        rs_cnt_d   = rs_cnt_q;
        case (rs_state_q)
            RS_IDLE: begin
                rs_state_d = RS_HOLD;
                rs_cnt_d   = {`CFH_RESET_CNT_W{1'b0}};
            end
            RS_HOLD: begin
                // Counts low cycles before release
                if (rs_cnt_q >= `CFH_RESET_CYCLES - 1) begin
                    rs_state_d = RS_DONE;
                end else begin
                    rs_cnt_d = rs_cnt_q + 1'b1;
                end
            end
            RS_DONE: begin
                // Software may start another reset pulse
                if (wr_ctrl && REG_WDATA_I[`CFH_CTRL_RESET]) begin
                    rs_state_d = RS_HOLD;
                    rs_cnt_d   = {`CFH_RESET_CNT_W{1'b0}};
                end
            end
            default: begin
                rs_state_d = RS_IDLE;
            end
        endcase
    end

    // Sequencer flops; filter reset output registered
    always @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            rs_state_q    <= RS_IDLE;
            rs_cnt_q      <= {`CFH_RESET_CNT_W{1'b0}};
            FLT_RESET_N_O <= 1'b0;
        end else begin
            rs_state_q    <= rs_state_d;
            rs_cnt_q      <= rs_cnt_d;
            FLT_RESET_N_O <= (rs_state_d == RS_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and rate registers
    always @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            bp_en_q     <= 1'b0;
            out_stall_q <= 1'b0;
            rate_q      <= `CFH_RESET_RATE;
        end else begin
            if (wr_ctrl) begin
                bp_en_q     <= REG_WDATA_I[`CFH_CTRL_BP_EN];
                out_stall_q <= REG_WDATA_I[`CFH_CTRL_OUT_STALL];
            end
            if (wr_rate && !cfg_busy && !flt_in_reset) begin
                rate_q <= REG_WDATA_I[`CFH_RATE_WIDTH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration channel: one rate word per write
    // Dropped while the filter is held in reset, so nothing is left pending
    cfh_stream_src #(
        .W (`CFH_RATE_PAD_WIDTH)
    ) u_cfg_src (
        .clk_i       (CLK_SYS_I),
        .rst_n_i     (RST_N_I && !flt_in_reset),
        .load_i      (wr_rate),
        .load_data_i (pack_rate(REG_WDATA_I)),
        .load_last_i (1'b0),
        .busy_o      (cfg_busy),
        .tvalid_o    (CFG_TVALID_O),
        .tdata_o     (CFG_TDATA_O),
        .tlast_o     (),
        .tready_i    (CFG_TREADY_I)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data input channel: marks the last channel's sample
    wire in_last = (in_chan_q == `CFH_NUM_CHAN - 1);

    cfh_stream_src #(
        .W (`CFH_IN_PAD_WIDTH)
    ) u_din_src (
        .clk_i       (CLK_SYS_I),
        .rst_n_i     (RST_N_I && !flt_in_reset),
        .load_i      (wr_sample),
        .load_data_i (pack_sample(REG_WDATA_I)),
        .load_last_i (in_last),
        .busy_o      (din_busy),
        .tvalid_o    (DIN_TVALID_O),
        .tdata_o     (DIN_TDATA_O),
        .tlast_o     (DIN_TLAST_O),
        .tready_i    (DIN_TREADY_I)
    );

    // Channel counter advances on each input transfer
    always @(posedge CLK_SYS_I) begin
        if (!RST_N_I || flt_in_reset) begin
            in_chan_q <= {`CFH_CHAN_WIDTH{1'b0}};
        end else if (DIN_TVALID_O && DIN_TREADY_I) begin
            in_chan_q <= in_last ? {`CFH_CHAN_WIDTH{1'b0}}
                                 : in_chan_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output channel: without backpressure ready is forced high
    // With backpressure, software stall lets the filter fill up
    assign DOUT_TREADY_O = !bp_en_q || !out_stall_q;
    wire out_take = DOUT_TVALID_I && DOUT_TREADY_O;

    // Capture side: newest sample wins, overrun flagged if unread
    always @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            out_data_q  <= {`CFH_OUT_PAD_WIDTH{1'b0}};
            out_user_q  <= {`CFH_USER_WIDTH{1'b0}};
            out_last_q  <= 1'b0;
            out_avail_q <= 1'b0;
            overrun_q   <= 1'b0;
            out_cnt_q   <= 16'h0000;
        end else begin
            if (out_take) begin
                // Sign-extended data, index at bit 0, marker above
                out_data_q <= DOUT_TDATA_I;
                out_user_q <= DOUT_TUSER_I;
                out_last_q <= DOUT_TLAST_I;
                out_cnt_q  <= out_cnt_q + 16'h0001;
            end
            // Set wins over the read clear
            if (out_take) begin
                out_avail_q <= 1'b1;
            end else if (rd_data) begin
                out_avail_q <= 1'b0;
            end
            if (out_take && out_avail_q && !rd_data) begin
                overrun_q <= 1'b1;
            end else if (wr_ctrl) begin
                overrun_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; unmapped reads zero
    always @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= 32'h00000000;
        end else if (REG_RD_I) begin
            case (REG_ADDR_I)
                `CFH_REG_CTRL:     REG_RDATA_O <= {29'h0, out_stall_q, bp_en_q, 1'b0};
                `CFH_REG_RATE:     REG_RDATA_O <= {18'h0, rate_q};
                `CFH_REG_STATUS:   REG_RDATA_O <= {24'h0, EVT_LAST_UNEXPECTED_I,
                                                   EVT_LAST_MISSING_I, overrun_q,
                                                   out_last_q, flt_in_reset,
                                                   out_avail_q, din_busy, cfg_busy};
                `CFH_REG_OUT_DATA: REG_RDATA_O <= {{8{out_data_q[`CFH_OUT_PAD_WIDTH-1]}},
                                                   out_data_q};
                `CFH_REG_OUT_USER: REG_RDATA_O <= {16'h0, out_user_q};
                `CFH_REG_COUNT:    REG_RDATA_O <= {16'h0, out_cnt_q};
                default:           REG_RDATA_O <= 32'h00000000;
            endcase
        end else begin
            REG_RDATA_O <= 32'h00000000;
        end
    end

endmodule // cfh_host

`default_nettype wire

// file: testbench/cfh_flt_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behavioural filter: four channels, output is the sign-extended input sample
module cfh_flt_model (
    // Clock, filter reset and test knobs
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        slow_i,
    input  wire logic        bp_i,
    // Configuration channel
    input  wire logic        cfg_tvalid_i,
    input  wire logic [15:0] cfg_tdata_i,
    output wire logic        cfg_tready_o,
    // Data input channel
    input  wire logic        din_tvalid_i,
    input  wire logic [15:0] din_tdata_i,
    input  wire logic        din_tlast_i,
    output wire logic        din_tready_o,
    // Data output channel and events
    output var  logic        dout_tvalid_o,
    output wire logic [23:0] dout_tdata_o,
    output var  logic [15:0] dout_tuser_o,
    output var  logic        dout_tlast_o,
    input  wire logic        dout_tready_i,
    output var  logic        evt_missing_o,
    output var  logic        evt_unexp_o
);
    logic [13:0] rate_q; // Accepted rate, padding dropped
    logic [1:0]  chan_q; // Channel of the next input
    logic [23:0] data_q; // Held output sample
    logic        tick_q; // Toggle that throttles readies in slow mode

    // Stale payload is inverted so nobody can lean on it
    assign dout_tdata_o = dout_tvalid_o ? data_q : ~data_q;
    assign cfg_tready_o = rst_n_i && !(slow_i && tick_q);
    // No room while an output is held, which stalls the source
    assign din_tready_o = rst_n_i && !dout_tvalid_o && !(slow_i && tick_q);

    // Handshakes, channel count and events
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            {rate_q, chan_q, dout_tvalid_o, evt_missing_o, evt_unexp_o, tick_q} <= '0;
        end else begin
            tick_q <= ~tick_q;
            if (cfg_tvalid_i && cfg_tready_o) rate_q <= cfg_tdata_i[13:0];
            // Without backpressure an output lasts one cycle only
            if (dout_tvalid_o && (dout_tready_i || !bp_i)) dout_tvalid_o <= 1'b0;
            if (din_tvalid_i && din_tready_o) begin
                dout_tvalid_o <= 1'b1;
                data_q <= {{8{din_tdata_i[15]}}, din_tdata_i};
                dout_tuser_o <= {7'h00, chan_q == 2'h0, 6'h00, chan_q};
                dout_tlast_o <= chan_q == 2'h3;
                evt_missing_o <= chan_q == 2'h3 && !din_tlast_i;
                evt_unexp_o <= chan_q != 2'h3 && din_tlast_i;
                chan_q <= chan_q + 2'h1;
            end
        end
    end
endmodule // cfh_flt_model

`default_nettype wire

// file: testbench/cfh_host_chk.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Port checker of the filter host
module cfh_host_chk (
    // Clock and reset
    input wire logic        CLK_SYS_I,
    input wire logic        RST_N_I,
    // Register port
    input wire logic [3:0]  REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic        REG_WR_I,
    // Filter side
    input wire logic        FLT_RESET_N_O,
    input wire logic        CFG_TVALID_O,
    input wire logic [15:0] CFG_TDATA_O,
    input wire logic        CFG_TREADY_I,
    input wire logic        DIN_TVALID_O,
    input wire logic [15:0] DIN_TDATA_O,
    input wire logic        DIN_TLAST_O,
    input wire logic        DIN_TREADY_I,
    input wire logic        DOUT_TVALID_I,
    input wire logic        DOUT_TREADY_O
);
    wire logic ctl = REG_WR_I && REG_ADDR_I == 4'h0; // Control write
    wire logic kill = ctl && REG_WDATA_I[0];         // Filter reset pulse request

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    ////////////////////////////////////////////////////////////////////////////
    // Reset behaviour must be seen while reset is low, so never disabled
    a_reset_clears: assert property (disable iff (1'b0) !RST_N_I |=>
        !CFG_TVALID_O && !DIN_TVALID_O && !FLT_RESET_N_O) else $error("valid high in reset");
    a_flt_low_len: assert property ($rose(FLT_RESET_N_O) |-> !$past(FLT_RESET_N_O, 2))
        else $error("filter reset too short");
    a_flt_drops: assert property (!FLT_RESET_N_O [*2] |-> !DIN_TVALID_O && !CFG_TVALID_O)
        else $error("valid survives filter reset");
    // A filter reset may legally drop a waiting word
    a_din_holds: assert property (DIN_TVALID_O && !DIN_TREADY_I && !kill |=>
        !FLT_RESET_N_O || DIN_TVALID_O && $stable(DIN_TDATA_O) && $stable(DIN_TLAST_O))
        else $error("input word changed before transfer");
    a_cfg_holds: assert property (CFG_TVALID_O && !CFG_TREADY_I && !kill |=>
        !FLT_RESET_N_O || CFG_TVALID_O && $stable(CFG_TDATA_O)) else $error("rate changed early");
    a_din_once: assert property (DIN_TVALID_O && DIN_TREADY_I |=> !DIN_TVALID_O)
        else $error("input word sent twice");
    a_sample_load: assert property (REG_WR_I && REG_ADDR_I == 4'h2 && FLT_RESET_N_O
        && !DIN_TVALID_O |=> DIN_TVALID_O && {16'h0, DIN_TDATA_O} == ($past(REG_WDATA_I) & 32'hFFFF))
        else $error("sample not offered");
    a_rate_load: assert property (REG_WR_I && REG_ADDR_I == 4'h1 && FLT_RESET_N_O
        && !CFG_TVALID_O |=> CFG_TVALID_O && {16'h0, CFG_TDATA_O} == ($past(REG_WDATA_I) & 32'h3FFF))
        else $error("rate not offered");
    a_ready_free: assert property (ctl && !REG_WDATA_I[1] |=> DOUT_TREADY_O)
        else $error("output stalled without backpressure");
    a_ready_stall: assert property (ctl && REG_WDATA_I[2:1] == 2'b11 |=> !DOUT_TREADY_O)
        else $error("stall not applied");

    // Main traffic seen
    c_din_xfer: cover property (DIN_TVALID_O && DIN_TREADY_I);
    c_cfg_xfer: cover property (CFG_TVALID_O && CFG_TREADY_I);
    c_out_stall: cover property (DOUT_TVALID_I && !DOUT_TREADY_O);
endmodule // cfh_host_chk

bind cfh_host cfh_host_chk u_chk (.CLK_SYS_I, .RST_N_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I,
    .FLT_RESET_N_O, .CFG_TVALID_O, .CFG_TDATA_O, .CFG_TREADY_I, .DIN_TVALID_O, .DIN_TDATA_O,
    .DIN_TLAST_O, .DIN_TREADY_I, .DOUT_TVALID_I, .DOUT_TREADY_O);

`default_nettype wire

// file: testbench/tb_cic_filter_stream_ports.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Software drives the host registers, the filter model answers on the streams
module tb_cic_filter_stream_ports;
    logic        CLK_SYS_I = 1'b0;    // 50 MHz system clock
    logic        RST_N_I = 1'b0;      // Synchronous reset
    logic [3:0]  REG_ADDR_I = 4'h0;   // Register index
    logic [31:0] REG_WDATA_I = 32'h0; // Write data
    logic        REG_WR_I = 1'b0;     // Write strobe
    logic        REG_RD_I = 1'b0;     // Read strobe
    logic [31:0] REG_RDATA_O, q;
    logic [23:0] DOUT_TDATA_I;
    logic [15:0] CFG_TDATA_O, DIN_TDATA_O, DOUT_TUSER_I;
    logic FLT_RESET_N_O, CFG_TVALID_O, CFG_TREADY_I, DIN_TVALID_O, DIN_TLAST_O, DIN_TREADY_I;
    logic DOUT_TVALID_I, DOUT_TLAST_I, DOUT_TREADY_O, EVT_LAST_MISSING_I, EVT_LAST_UNEXPECTED_I;
    logic slow = 1'b0; // Model throttles its readies
    logic bp = 1'b0;   // Model holds outputs until taken
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;
    // Rows: sample in, expected data word and side-band out
    logic [15:0] smp [4] = '{16'h8001, 16'h7FFF, 16'h0000, 16'hFFFF};
    logic [31:0] exd [4] = '{32'hFFFF8001, 32'h00007FFF, 32'h00000000, 32'hFFFFFFFF};
    logic [15:0] exu [4] = '{16'h0100, 16'h0001, 16'h0002, 16'h0003};
    logic [13:0] rt [2] = '{14'h0004, 14'h2000}; // Rate extremes

    cfh_host dut (.CLK_SYS_I, .RST_N_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
        .REG_RDATA_O, .FLT_RESET_N_O, .CFG_TVALID_O, .CFG_TDATA_O, .CFG_TREADY_I,
        .DIN_TVALID_O, .DIN_TDATA_O, .DIN_TLAST_O, .DIN_TREADY_I, .DOUT_TVALID_I,
        .DOUT_TDATA_I, .DOUT_TUSER_I, .DOUT_TLAST_I, .DOUT_TREADY_O,
        .EVT_LAST_MISSING_I, .EVT_LAST_UNEXPECTED_I);
    cfh_flt_model u_flt (.clk_i(CLK_SYS_I), .rst_n_i(FLT_RESET_N_O), .slow_i(slow), .bp_i(bp),
        .cfg_tvalid_i(CFG_TVALID_O), .cfg_tdata_i(CFG_TDATA_O), .cfg_tready_o(CFG_TREADY_I),
        .din_tvalid_i(DIN_TVALID_O), .din_tdata_i(DIN_TDATA_O), .din_tlast_i(DIN_TLAST_O),
        .din_tready_o(DIN_TREADY_I), .dout_tvalid_o(DOUT_TVALID_I), .dout_tdata_o(DOUT_TDATA_I),
        .dout_tuser_o(DOUT_TUSER_I), .dout_tlast_o(DOUT_TLAST_I), .dout_tready_i(DOUT_TREADY_O),
        .evt_missing_o(EVT_LAST_MISSING_I), .evt_unexp_o(EVT_LAST_UNEXPECTED_I));

    always #10 CLK_SYS_I = ~CLK_SYS_I;

    ////////////////////////////////////////////////////////////////////////////
    // Bus tasks end 1 ns past the edge so no strobe is set twice in one step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        REG_WR_I <= 1'b1;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        @(posedge CLK_SYS_I);
        REG_WR_I <= 1'b0;
        #1;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        REG_RD_I <= 1'b1;
        REG_ADDR_I <= a;
        @(posedge CLK_SYS_I);
        REG_RD_I <= 1'b0;
        #1 d = REG_RDATA_O;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait on one status bit
    task automatic poll(input int b, input logic v);
        logic [31:0] s;
        for (int k = 0; k < 40; k++) begin
            rd(4'h3, s);
            if (s[b] === v) return;
        end
        chk({31'h0, s[b]}, {31'h0, v});
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Hang guard, far above the fewer than a hundred cycles the run needs
    always @(posedge CLK_SYS_I) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge CLK_SYS_I);
        #1 chk({29'h0, FLT_RESET_N_O, DIN_TVALID_O, CFG_TVALID_O}, 32'h0);
        @(posedge CLK_SYS_I);
        RST_N_I <= 1'b1;
        #1 poll(3, 1'b0);
        // Rates with padding bits set; the filter must see them cleared
        foreach (rt[i]) begin
            wr(4'h1, {16'h0, 2'b11, rt[i]});
            poll(0, 1'b0);
            chk({18'h0, u_flt.rate_q}, {18'h0, rt[i]});
        end
        // Row loop: one full frame, alternating model throttling
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            wr(4'h2, {16'h0, smp[i]});
            poll(2, 1'b1);
            rd(4'h4, q);
            chk(q, exd[i]);
            rd(4'h5, q);
            chk(q, {16'h0, exu[i]});
        end
        rd(4'h3, q);
        chk({30'h0, q[7:6]}, 32'h0);
        // Stalled output: second word waits, third is refused
        bp <= 1'b1;
        wr(4'h0, 32'h6);
        wr(4'h2, 32'h8000);
        poll(1, 1'b0);
        wr(4'h2, 32'h0042);
        wr(4'h2, 32'h0077);
        chk({15'h0, DOUT_TREADY_O, DIN_TDATA_O}, 32'h0042);
        wr(4'h0, 32'h2);
        poll(2, 1'b1);
        rd(4'h4, q);
        chk(q, 32'hFFFF8000);
        poll(2, 1'b1);
        rd(4'h4, q);
        chk(q, 32'h00000042);
        rd(4'h3, q);
        chk({31'h0, q[2]}, 32'h0);
        // Filter reset in mid-frame restarts the channel count
        wr(4'h0, 32'h6);
        wr(4'h2, 32'h0011);
        wr(4'h0, 32'h7);
        poll(3, 1'b0);
        bp <= 1'b0;
        wr(4'h0, 32'h0);
        wr(4'h2, 32'hFFFE);
        poll(2, 1'b1);
        rd(4'h5, q);
        chk(q, 32'h0100);
        rd(4'h4, q);
        chk(q, 32'hFFFFFFFE);
        // Seven outputs taken; the sample cut by the filter reset never arrives
        rd(4'h6, q);
        chk(q, 32'h00000007);
        rd(4'h1, q);
        chk(q, 32'h00002000);
        stop_test();
    end
endmodule // tb_cic_filter_stream_ports

`default_nettype wire
